// *** rtl/bridge_corr_pkg.sv ***
/*
 bridge_corr_pkg: register offsets, field positions, reset values,
 fixed-point shifts for the bridge correction datapath.
 assumes one sys_clk domain; all users import the whole package.
*/
// How it works
// RL1: host computes all coefficients offline and writes them into memory.
// RL2: raw bridge sample is unsigned 0..16383, one count per step.
// RL3: raw temperature sample is unsigned 0..16383, step of four counts.
// RL4: bridge gain bit 14 multiplies the lower gain by eight, range 64.
// RL5: bridge gain bits 13:0 are fraction 0..8, bit 13 weighs 4.
// RL6: bridge offset is 14-bit unsigned, top bit weighs 8192.
// RL7: temperature gain is 8-bit fraction 0..2, bit 7 weighs 1.
// RL8: temperature offset is 8-bit two's complement, top bit -128.
// RL9: low reference is upper seven bits of temperature at calibration.
// RL10: offset tempco is magnitude, sign and scale-by-eight bit.
// RL11: gain tempco is magnitude and sign, never scaled.
// RL12: second-order term feeds at most one target, chosen by two bits; code 11 feeds none.
// RL13: offset tempco scale bit also scales second-order part by eight.
// RL14: bridge math saturates instead of wrapping.
// RL15: target 00 bridge, 01 gain tempco, 10 offset tempco, 11 barred.
// RL16: second-order coefficient is sign bit 7 and magnitude 6:0.
// RL17: options bit 2 negates gain tempco, bit 0 negates offset tempco.
// RL18: full-precision fixed point, rounded once to a 14-bit result.
package bridge_corr_pkg;

    typedef logic signed [47:0] acc_t;

    // ************************************************
    // register map
    // ************************************************
    localparam logic [5:0] OFF_BGAIN = 6'h00;
    localparam logic [5:0] OFF_BOFF = 6'h04;
    localparam logic [5:0] OFF_TGAIN = 6'h08;
    localparam logic [5:0] OFF_TOFF = 6'h0C;
    localparam logic [5:0] OFF_TREF = 6'h10;
    localparam logic [5:0] OFF_TCG = 6'h14;
    localparam logic [5:0] OFF_TCO = 6'h18;
    localparam logic [5:0] OFF_TCOPT = 6'h1C;
    localparam logic [5:0] OFF_SQCOEF = 6'h20;
    localparam logic [5:0] OFF_TGT = 6'h24;
    localparam logic [5:0] OFF_STATUS = 6'h28;
    localparam logic [5:0] OFF_RES_B = 6'h2C;
    localparam logic [5:0] OFF_RES_T = 6'h30;

    // ************************************************
    // fields and reset values
    // ************************************************
    localparam int GB_SCALE_BIT = 14;
    localparam int TCO_NEG_BIT = 0;
    localparam int TCO_SCALE_BIT = 1;
    localparam int TCG_NEG_BIT = 2;
    localparam int SQ_SIGN_BIT = 7;
    localparam int ST_CLR_BIT = 1;
    localparam logic [1:0] TGT_BRIDGE = 2'h0;
    localparam logic [1:0] TGT_TCG = 2'h1;
    localparam logic [1:0] TGT_TCO = 2'h2;
    localparam logic [1:0] TGT_BAD = 2'h3;
    localparam logic [14:0] RST_BGAIN = 15'h0800;
    localparam logic [7:0] RST_TGAIN = 8'h80;
    localparam logic [1:0] RST_TGT = 2'h1;
    localparam logic [13:0] RAW_MAX = 14'h3FFF;

    // ************************************************
    // fixed-point shifts
    // ************************************************
    localparam int GB_FRAC = 11;
    localparam int GT_FRAC = 7;
    localparam int TOFF_SHIFT = 2;
    localparam int TC_SCALE_SHIFT = 3;
    localparam int SQ_TC_SHIFT = 4;
    localparam int TCO_SHIFT = 4;
    localparam int TCG_SHIFT = 16;
    localparam int SQ_SHIFT = 14;
    localparam int SQ_BR_SHIFT = 9;
    localparam int SQ_LIMIT = 131072;

endpackage : bridge_corr_pkg

// *** rtl/bridge_correction_math.sv ***
/*
 bridge_correction_math: coefficient registers and two-stage
 correction pipeline for bridge and temperature samples.
 assumes samples come from logic on sys_clk, so no synchroniser.
*/
`timescale 1ns/1ps
module bridge_correction_math
    import bridge_corr_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // raw samples
    input wire logic sample_valid,
    input wire logic [13:0] raw_bridge_sample,
    input wire logic [13:0] raw_temp_sample,
    // corrected results
    output logic result_valid,
    output logic [13:0] corr_bridge,
    output logic [13:0] corr_temp,
    output logic saturated
);

    // ************************************************
    // helpers
    // ************************************************
    function automatic acc_t uext(input logic [15:0] v);
        return acc_t'({32'h0000_0000, v});
    endfunction : uext

    function automatic acc_t sign_mag(input logic neg,
                                      input logic [7:0] mag);
        return neg ? -uext({8'h00, mag}) : uext({8'h00, mag});
    endfunction : sign_mag

    function automatic logic [13:0] sat14(input acc_t v);
        if (v < 0)
            return 14'h0000;
        if (v > uext({2'h0, RAW_MAX}))
            return RAW_MAX;
        return v[13:0];
    endfunction : sat14

    function automatic logic out_of_range(input acc_t v);
        return (v < 0) || (v > uext({2'h0, RAW_MAX}));
    endfunction : out_of_range

    // ************************************************
    // coefficient registers
    // ************************************************
    logic [14:0] bgain_reg;
    logic [13:0] boff_reg;
    logic [7:0] tgain_reg;
    logic [7:0] toff_reg;
    logic [6:0] tref_reg;
    logic [7:0] tcg_reg;
    logic [7:0] tco_reg;
    logic [2:0] tcopt_reg;
    logic [7:0] sq_coef_reg;
    logic [1:0] tgt_reg;
    logic satst_reg;
    logic satst_next;
    logic [15:0] reg_rdata_reg;

    wire wr_en = reg_wr && clk_en;
    wire rd_en = reg_rd && clk_en;
    wire clr_sat = wr_en && (reg_addr == OFF_STATUS)
                   && reg_wdata[ST_CLR_BIT];

    // ************************************************
    // second-order target decode
    // ************************************************
    wire so_br = (tgt_reg == TGT_BRIDGE); // [RL15]
    wire so_tcg = (tgt_reg == TGT_TCG); // [RL15]
    wire so_tco = (tgt_reg == TGT_TCO); // [RL15]
    // barred code drives no target; reported in status
    wire bad_tgt = (tgt_reg == TGT_BAD); // [RL12]

    // ************************************************
    // stage a: temperature and tempco terms
    // ************************************************
    logic vld_a_reg;
    logic [13:0] br_a_reg;
    logic [13:0] tcorr_a_reg;
    acc_t dt_a_reg;
    acc_t tco_a_reg;
    acc_t tcg_a_reg;

    // temperature keeps its four-count steps at full width
    wire acc_t t_acc = uext({2'h0, raw_temp_sample}); // [RL3]
    wire acc_t gt = uext({8'h00, tgain_reg}); // [RL7]
    wire acc_t ot = acc_t'(signed'(toff_reg)); // [RL8]
    wire acc_t tcorr_a = ((t_acc * gt) >>> GT_FRAC)
                         + (ot <<< TOFF_SHIFT); // [RL3]
    wire acc_t dt_a = uext({9'h000, raw_temp_sample[13:7]})
                      - uext({9'h000, tref_reg}); // [RL9]
    wire acc_t tco_b = sign_mag(tcopt_reg[TCO_NEG_BIT],
                                tco_reg); // [RL10] [RL17]
    wire acc_t tcg_b = sign_mag(tcopt_reg[TCG_NEG_BIT],
                                tcg_reg); // [RL11] [RL17]
    wire acc_t sq_coef = sign_mag(sq_coef_reg[SQ_SIGN_BIT],
                                  {1'b0, sq_coef_reg[6:0]}); // [RL16]
    wire acc_t sq_dt = (sq_coef * dt_a) >>> SQ_TC_SHIFT;
    wire acc_t tco_sum = tco_b + (so_tco ? sq_dt : '0); // [RL12]
    // scale after the sum so the second-order part scales too
    wire acc_t tco_tot = tcopt_reg[TCO_SCALE_BIT]
                         ? (tco_sum <<< TC_SCALE_SHIFT)
                         : tco_sum; // [RL10] [RL13]
    wire acc_t tcg_tot = tcg_b + (so_tcg ? sq_dt : '0); // [RL11]

    // ************************************************
    // stage b: bridge correction
    // ************************************************
    wire acc_t br_acc = uext({2'h0, br_a_reg}); // [RL2]
    wire acc_t off_comp = uext({2'h0, boff_reg})
                          + ((tco_a_reg * dt_a_reg) >>> TCO_SHIFT); // [RL6]
    wire acc_t x_b = br_acc - off_comp;
    wire acc_t gbase = uext({2'h0, bgain_reg[13:0]}); // [RL5]
    wire acc_t gfull = bgain_reg[GB_SCALE_BIT]
                       ? (gbase <<< TC_SCALE_SHIFT) : gbase; // [RL4]
    wire acc_t gtc = gfull
                     + ((gfull * tcg_a_reg * dt_a_reg) >>> TCG_SHIFT);
    wire acc_t round_b = acc_t'(1) <<< (GB_FRAC - 1);
    wire acc_t y1 = ((x_b * gtc) + round_b) >>> GB_FRAC; // [RL18]
    // clamp before squaring so the product cannot wrap
    wire acc_t y_lim = acc_t'(SQ_LIMIT);
    wire acc_t yc = (y1 > y_lim) ? y_lim
                    : ((y1 < -y_lim) ? -y_lim : y1); // [RL14]
    wire acc_t sq = (yc * yc) >>> SQ_SHIFT;
    wire acc_t y2 = so_br ? y1 + ((sq_coef * sq) >>> SQ_BR_SHIFT)
                    : y1; // [RL12]
    wire sat_b = out_of_range(y2); // [RL14]
    wire acc_t tc_clip = acc_t'(signed'({1'b0, tcorr_a_reg}));

    // ************************************************
    // register read mux
    // ************************************************
    wire [15:0] status_w = {13'h0000, bad_tgt, satst_reg, vld_a_reg};
    wire [15:0] rd_mux =
        (reg_addr == OFF_BGAIN) ? {1'b0, bgain_reg} :
        (reg_addr == OFF_BOFF) ? {2'h0, boff_reg} :
        (reg_addr == OFF_TGAIN) ? {8'h00, tgain_reg} :
        (reg_addr == OFF_TOFF) ? {8'h00, toff_reg} :
        (reg_addr == OFF_TREF) ? {9'h000, tref_reg} :
        (reg_addr == OFF_TCG) ? {8'h00, tcg_reg} :
        (reg_addr == OFF_TCO) ? {8'h00, tco_reg} :
        (reg_addr == OFF_TCOPT) ? {13'h0000, tcopt_reg} :
        (reg_addr == OFF_SQCOEF) ? {8'h00, sq_coef_reg} :
        (reg_addr == OFF_TGT) ? {14'h0000, tgt_reg} :
        (reg_addr == OFF_STATUS) ? status_w :
        (reg_addr == OFF_RES_B) ? {2'h0, corr_bridge} :
        (reg_addr == OFF_RES_T) ? {2'h0, corr_temp} :
        16'h0000;

    // a saturation in the clearing cycle survives the clear
    assign satst_next = (result_valid && saturated)
                        || (satst_reg && !clr_sat);
    assign reg_rdata = reg_rdata_reg;

    // ************************************************
    // register file
    // ************************************************
    // written by the host's coefficient load path
    always_ff @(posedge sys_clk or negedge rst_b) begin // [RL1]
        if (!rst_b) begin
            bgain_reg <= RST_BGAIN;
            boff_reg <= 14'h0000;
            tgain_reg <= RST_TGAIN;
            toff_reg <= 8'h00;
            tref_reg <= 7'h00;
            tcg_reg <= 8'h00;
            tco_reg <= 8'h00;
            tcopt_reg <= 3'h0;
            sq_coef_reg <= 8'h00;
            tgt_reg <= RST_TGT;
        end else if (wr_en) begin
            case (reg_addr)
                OFF_BGAIN: bgain_reg <= reg_wdata[14:0];
                OFF_BOFF: boff_reg <= reg_wdata[13:0];
                OFF_TGAIN: tgain_reg <= reg_wdata[7:0];
                OFF_TOFF: toff_reg <= reg_wdata[7:0];
                OFF_TREF: tref_reg <= reg_wdata[6:0];
                OFF_TCG: tcg_reg <= reg_wdata[7:0];
                OFF_TCO: tco_reg <= reg_wdata[7:0];
                OFF_TCOPT: tcopt_reg <= reg_wdata[2:0];
                OFF_SQCOEF: sq_coef_reg <= reg_wdata[7:0];
                OFF_TGT: tgt_reg <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_reg <= 16'h0000;
            satst_reg <= 1'b0;
        end else if (clk_en) begin
            reg_rdata_reg <= rd_en ? rd_mux : 16'h0000;
            satst_reg <= satst_next; // [RL14]
        end
    end

    // ************************************************
    // pipeline
    // ************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vld_a_reg <= 1'b0;
            br_a_reg <= 14'h0000;
            tcorr_a_reg <= 14'h0000;
            dt_a_reg <= '0;
            tco_a_reg <= '0;
            tcg_a_reg <= '0;
        end else if (clk_en) begin
            vld_a_reg <= sample_valid;
            if (sample_valid) begin
                br_a_reg <= raw_bridge_sample; // [RL2]
                tcorr_a_reg <= sat14(tcorr_a);
                dt_a_reg <= dt_a;
                tco_a_reg <= tco_tot;
                tcg_a_reg <= tcg_tot;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            result_valid <= 1'b0;
            corr_bridge <= 14'h0000;
            corr_temp <= 14'h0000;
            saturated <= 1'b0;
        end else if (clk_en) begin
            result_valid <= vld_a_reg; // [RL18]
            if (vld_a_reg) begin
                corr_bridge <= sat14(y2); // [RL14] [RL18]
                corr_temp <= sat14(tc_clip);
                saturated <= sat_b;
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    a_bridge_capture: assert property ( // [RL2]
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && sample_valid |=> br_a_reg == $past(raw_bridge_sample))
        else $error("bridge sample not captured");

    a_temp_unity: assert property ( // [RL3]
        @(posedge sys_clk) disable iff (!rst_b)
        tgain_reg == RST_TGAIN && toff_reg == 8'h00 |-> tcorr_a == t_acc)
        else $error("unity temperature path altered sample");

    a_gain_scale: assert property ( // [RL4]
        @(posedge sys_clk) disable iff (!rst_b)
        bgain_reg[GB_SCALE_BIT] |-> gfull == gbase * 8)
        else $error("gain scale flag not applied");

    a_gain_frac: assert property ( // [RL5]
        @(posedge sys_clk) disable iff (!rst_b)
        !bgain_reg[GB_SCALE_BIT] |-> gfull < uext(16'h4000))
        else $error("gain fraction out of range");

    a_offset_plain: assert property ( // [RL6]
        @(posedge sys_clk) disable iff (!rst_b)
        tco_a_reg == 0 |-> off_comp == uext({2'h0, boff_reg}))
        else $error("bridge offset decode wrong");

    a_temp_offset: assert property ( // [RL7] [RL8]
        @(posedge sys_clk) disable iff (!rst_b)
        tgain_reg == 8'h00 |-> (tcorr_a < 0) == toff_reg[7])
        else $error("temperature offset sign wrong");

    a_tco_scale: assert property ( // [RL10]
        @(posedge sys_clk) disable iff (!rst_b)
        tcopt_reg[TCO_SCALE_BIT] && !so_tco |-> tco_tot == tco_b * 8)
        else $error("offset tempco not scaled");

    a_tcg_plain: assert property ( // [RL11]
        @(posedge sys_clk) disable iff (!rst_b)
        !so_tcg |-> tcg_tot == tcg_b)
        else $error("gain tempco altered");

    a_one_target: assert property ( // [RL12]
        @(posedge sys_clk) disable iff (!rst_b)
        $onehot0({so_br, so_tcg, so_tco}) && (bad_tgt == !(so_br
            || so_tcg || so_tco)))
        else $error("second-order target not unique");

    a_sq_scaled: assert property ( // [RL13]
        @(posedge sys_clk) disable iff (!rst_b)
        so_tco && tcopt_reg[TCO_SCALE_BIT]
        |-> tco_tot == (tco_b + sq_dt) * 8)
        else $error("second-order part not scaled");

    a_out_sat: assert property ( // [RL14]
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && vld_a_reg && y2 < 0 |=> corr_bridge == 14'h0000
        && saturated && result_valid)
        else $error("negative bridge result wrapped");

    a_target_code: assert property ( // [RL15]
        @(posedge sys_clk) disable iff (!rst_b)
        tgt_reg == TGT_TCO |-> so_tco && !so_br && !so_tcg)
        else $error("target decode wrong");

    a_sq_sign: assert property ( // [RL16]
        @(posedge sys_clk) disable iff (!rst_b)
        sq_coef_reg[6:0] != 7'h00 |-> (sq_coef < 0) == sq_coef_reg[7])
        else $error("second-order sign wrong");

    a_tc_negate: assert property ( // [RL17]
        @(posedge sys_clk) disable iff (!rst_b)
        tcg_reg != 8'h00 |-> (tcg_b < 0) == tcopt_reg[TCG_NEG_BIT])
        else $error("gain tempco sign wrong");

    a_latency: assert property ( // [RL18]
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && sample_valid ##1 clk_en |-> ##1 result_valid)
        else $error("result not two cycles after sample");

    a_sat_sticky: assert property ( // [RL14]
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && result_valid && saturated |=> satst_reg)
        else $error("saturation flag lost");

endmodule : bridge_correction_math

// *** verif/bridge_correction_math_tb.sv ***
/*
 bridge_correction_math_tb: self-checking bench for the datapath.
 assumes the calib_host model drives the register port.
*/
`timescale 1ns/1ps
module bridge_correction_math_tb;
    import bridge_corr_pkg::*;
    logic sys_clk, rst_b, clk_en, reg_wr, reg_rd, sample_valid;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [13:0] raw_bridge_sample, raw_temp_sample;
    logic result_valid, saturated;
    logic [13:0] corr_bridge, corr_temp;
    int err_count, total_checks;
    logic [14:0] gb;
    logic [13:0] ob;
    logic [7:0] gt, ot, tcg_m, tco_m, sq_m;
    logic [6:0] tref;
    logic [2:0] opt;
    logic [1:0] tgt;
    localparam logic [15:0] MASKS [10] = '{16'h7FFF, 16'h3FFF, 16'h00FF,
        16'h00FF, 16'h007F, 16'h00FF, 16'h00FF, 16'h0007, 16'h00FF, 16'h0003};

    bridge_correction_math i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .raw_bridge_sample(raw_bridge_sample),
        .raw_temp_sample(raw_temp_sample), .result_valid(result_valid),
        .corr_bridge(corr_bridge), .corr_temp(corr_temp),
        .saturated(saturated));
    calib_host i_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    // ************************************************
    // checking helpers
    // ************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // reference model in wide integers, so nothing wraps before clipping
    function automatic void model(input logic [13:0] rb, input logic [13:0] rt,
        output logic [13:0] eb, output logic [13:0] et, output logic es);
        longint dt, tco, tcg, sv, g, y, c, tv;
        dt = longint'(rt[13:7]) - longint'(tref);
        tco = opt[TCO_NEG_BIT] ? -longint'(tco_m) : longint'(tco_m);
        tcg = opt[TCG_NEG_BIT] ? -longint'(tcg_m) : longint'(tcg_m);
        sv = sq_m[7] ? -longint'(sq_m[6:0]) : longint'(sq_m[6:0]);
        if (tgt == TGT_TCO) tco += (sv * dt) >>> 4;
        if (tgt == TGT_TCG) tcg += (sv * dt) >>> 4;
        if (opt[TCO_SCALE_BIT]) tco *= 8;
        g = longint'(gb[13:0]) * (gb[14] ? 8 : 1);
        g += (g * tcg * dt) >>> 16;
        y = longint'(rb) - longint'(ob) - ((tco * dt) >>> 4);
        y = (y * g + 1024) >>> 11;
        if (tgt == TGT_BRIDGE) begin
            c = y > 131072 ? 131072 : (y < -131072 ? -131072 : y);
            y += (sv * ((c * c) >>> 14)) >>> 9;
        end
        es = (y < 0) || (y > 16383);
        eb = es ? (y < 0 ? 14'h0000 : 14'h3FFF) : y[13:0];
        tv = ((longint'(rt) * longint'(gt)) >>> 7) + longint'($signed(ot)) * 4;
        et = tv < 0 ? 14'h0000 : (tv > 16383 ? 14'h3FFF : tv[13:0]);
    endfunction : model

    task automatic go(input logic [13:0] rb, input logic [13:0] rt);
        logic [13:0] eb, et;
        logic es;
        i_host.wr(OFF_BGAIN, {1'b0, gb});
        i_host.wr(OFF_BOFF, {2'h0, ob});
        i_host.wr(OFF_TGAIN, {8'h00, gt});
        i_host.wr(OFF_TOFF, {8'h00, ot});
        i_host.wr(OFF_TREF, {9'h000, tref});
        i_host.wr(OFF_TCG, {8'h00, tcg_m});
        i_host.wr(OFF_TCO, {8'h00, tco_m});
        i_host.wr(OFF_TCOPT, {13'h0000, opt});
        i_host.wr(OFF_SQCOEF, {8'h00, sq_m});
        i_host.wr(OFF_TGT, {14'h0000, tgt});
        model(rb, rt, eb, et, es);
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        raw_bridge_sample <= rb;
        raw_temp_sample <= rt;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        raw_bridge_sample <= ~rb;
        raw_temp_sample <= ~rt;
        @(negedge sys_clk);
        chk({15'h0000, result_valid}, 16'h0000);
        @(negedge sys_clk);
        chk({15'h0000, result_valid}, 16'h0001);
        chk({2'h0, corr_bridge}, {2'h0, eb});
        chk({2'h0, corr_temp}, {2'h0, et});
        chk({15'h0000, saturated}, {15'h0000, es});
    endtask : go

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset_vals();
        for (int i = 0; i < 16; i++) begin
            i_host.rd(6'(i * 4), d);
            chk(d, i == 0 ? 16'h0800 : i == 2 ? 16'h0080 :
                i == 9 ? 16'h0001 : 16'h0000);
        end
        @(negedge sys_clk);
        chk(reg_rdata, 16'h0000);
    endtask : t_reset_vals

    task automatic t_regs();
        @(posedge sys_clk);
        clk_en <= 1'b0;
        i_host.wr(OFF_TGAIN, 16'h0011);
        clk_en <= 1'b1;
        i_host.rd(OFF_TGAIN, d);
        chk(d, 16'h0080);
        for (int i = 0; i < 10; i++) begin
            i_host.wr(6'(i * 4), 16'hFFFF);
            i_host.rd(6'(i * 4), d);
            chk(d, MASKS[i]);
        end
        i_host.wr(OFF_RES_B, 16'h1234);
        i_host.rd(OFF_RES_B, d);
        chk(d, 16'h0000);
        i_host.rd(OFF_STATUS, d);
        chk(d, 16'h0004);
    endtask : t_regs

    task automatic t_math();
        go(14'h3FFF, 14'h3FFC);
        gb = 15'h2531;
        go(14'h0400, 14'h1000);
        gb = 15'h4800;
        go(14'h0300, 14'h1000);
        gb = 15'h0800;
        ob = 14'h2000;
        go(14'h3000, 14'h1000);
        gt = 8'hFF;
        ot = 8'h80;
        go(14'h3000, 14'h2000);
        gt = 8'h00;
        go(14'h3000, 14'h2000);
        ob = 14'h0000;
        gt = 8'h80;
        ot = 8'h29;
        tref = 7'h10;
        tco_m = 8'h40;
        opt = 3'b011;
        go(14'h1000, 14'h1800);
        tco_m = 8'h00;
        tcg_m = 8'hFF;
        opt = 3'b100;
        go(14'h1000, 14'h3000);
        tgt = TGT_BRIDGE;
        sq_m = 8'hFF;
        gb = 15'h4800;
        go(14'h3FFF, 14'h1000);
        i_host.rd(OFF_STATUS, d);
        chk(d, 16'h0002);
        i_host.wr(OFF_STATUS, 16'h0002);
        i_host.rd(OFF_STATUS, d);
        chk(d, 16'h0000);
        gb = 15'h0800;
        tcg_m = 8'h20;
        tco_m = 8'h10;
        opt = 3'b010;
        for (int k = 0; k < 4; k++) begin
            tgt = 2'(k);
            sq_m = 8'hC0;
            go(14'h1000, 14'h1000);
            sq_m = 8'h40;
            go(14'h1000, 14'h1000);
        end
        i_host.rd(OFF_STATUS, d);
        chk(d, 16'h0004);
        // large gain drives the result past the top: clipped and flagged
        gb = 15'h4800;
        go(14'h3FFF, 14'h1000);
        i_host.rd(OFF_STATUS, d);
        chk(d, 16'h0006);
    endtask : t_math

    task automatic t_pipe();
        logic [13:0] b0, t0, b1, t1;
        logic s0, s1;
        model(14'h0123, 14'h0400, b0, t0, s0);
        model(14'h2345, 14'h3000, b1, t1, s1);
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        raw_bridge_sample <= 14'h0123;
        raw_temp_sample <= 14'h0400;
        @(posedge sys_clk);
        raw_bridge_sample <= 14'h2345;
        raw_temp_sample <= 14'h3000;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        clk_en <= 1'b0;
        @(negedge sys_clk);
        chk({result_valid, 1'b0, corr_bridge}, {2'h2, b0});
        @(posedge sys_clk);
        clk_en <= 1'b1;
        @(negedge sys_clk);
        chk({2'h0, corr_temp}, {2'h0, t0});
        @(negedge sys_clk);
        chk({result_valid, 1'b0, corr_bridge}, {2'h2, b1});
        chk({2'h0, corr_temp}, {2'h0, t1});
        @(negedge sys_clk);
        chk({15'h0000, result_valid}, 16'h0000);
    endtask : t_pipe

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // ************************************************
    // clock, reset, sequence
    // ************************************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        sample_valid = 1'b0;
        raw_bridge_sample = 14'h0000;
        raw_temp_sample = 14'h0000;
        err_count = 0;
        total_checks = 0;
        gb = RST_BGAIN;
        ob = 14'h0000;
        gt = RST_TGAIN;
        ot = 8'h00;
        tref = 7'h00;
        tcg_m = 8'h00;
        tco_m = 8'h00;
        opt = 3'h0;
        sq_m = 8'h00;
        tgt = RST_TGT;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset_vals();
        t_regs();
        t_math();
        t_pipe();
        summarize();
    end

    // whole run is near 520 cycles; nineteen times that means a hang
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule : bridge_correction_math_tb

// *** verif/calib_host.sv ***
/*
 calib_host: behavioural calibration host on the register port.
 assumes sys_clk from the bench; the bench calls wr and rd.
*/
`timescale 1ns/1ps
module calib_host (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [5:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // coefficients are worked out off chip, only stored here
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // released lines never keep the old value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd
endmodule : calib_host
